// [src/can_irq_enable_forward_regs.vh]
// Register map constants for the CAN interrupt-enable and filter forward-enable registers.
// Assumes an 8-bit external special-function register space with 16-bit byte addresses.
`ifndef CAN_IRQ_ENABLE_FORWARD_REGS_VH
`define CAN_IRQ_ENABLE_FORWARD_REGS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ADDR_INTERRUPT_ENABLE 16'h0B04
`define ADDR_FORWARD_ENABLE_HI 16'h0B05
`define ADDR_FORWARD_ENABLE_MID_HI 16'h0B06

// ****************************************************************
// Interrupt-enable field positions
// ****************************************************************
`define BIT_RECEIVE_IRQ_EN 0
`define BIT_TRANSMIT_IRQ_EN 1
`define BIT_ERROR_WARNING_IRQ_EN 2
`define BIT_IRQ_EN_RESERVED 4

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define RST_INTERRUPT_ENABLE 8'h00
`define RST_FORWARD_ENABLE_HI 8'h00
`define RST_FORWARD_ENABLE_MID_HI 8'h00
`define MASK_INTERRUPT_ENABLE 8'hEF
`define RST_READ_DATA 8'h00

`endif

// [src/can_irq_enable_forward_regs_top.v]
// Interrupt-enable register and forward-enable registers for filters 16 to 31 of a CAN controller.
// Assumes the CPU register strobes, the mode level and the protocol engine status all run on i_clk.
//
// Behaviour
// - Error-warning enable set: error or bus status change requests an interrupt.
// - Transmit enable set: successful transmission or buffer release requests an interrupt.
// - Receive enable set and receive buffer full requests an interrupt.
// - Interrupt-enable register is CPU readable and writable except reserved bit 4, which stays zero; all bits reset to zero.
// - Upper forward register bit 7..0 maps filters 31..24, reset zero.
// - Second forward register bit 7..0 maps filters 23..16, reset zero.
// - A cleared forward bit stops forwarding of messages matched by its filter.
// - Forward registers accept CPU writes only in silent mode.
// - In operating mode the forward registers are read-only.
// - Transmit flag sets on transmit buffer status rising while transmit enable is set.
// - Receive flag follows FIFO not empty with enable; flag register read keeps it.
`timescale 1ns/1ns
`include "can_irq_enable_forward_regs.vh"

module can_irq_enable_forward_regs_top (
   // Clock, reset and clock enable.
   input wire i_clk,
   input wire i_arst_n,
   input wire i_clk_en,
   // CPU register port.
   input wire [15:0] i_xfr_addr,
   input wire i_xfr_wr,
   input wire i_xfr_rd,
   input wire [7:0] i_xfr_wdata,
   output reg [7:0] o_xfr_rdata,
   output reg o_xfr_rvalid,
   // Controller mode.
   input wire i_silent_mode,
   // Protocol engine status.
   input wire i_err_status_change,
   input wire i_tx_done,
   input wire i_tx_buf_released,
   input wire i_rx_fifo_not_empty,
   input wire i_flag_reg_read,
   // Acceptance filter matches for filters 31 down to 16.
   input wire [15:0] i_filter_hit,
   // Interrupt flags and request.
   output reg o_error_warning_irq_flag,
   output reg o_transmit_irq_flag,
   output reg o_receive_irq_flag,
   output wire o_irq,
   // Forward enables and forward decision.
   output wire [15:0] o_forward_en,
   output reg o_forward_msg
);

   // ****************************************************************
   // Reset release
   // ****************************************************************

   // The reset is asserted at once but released only after two clean edges.
   reg rst_sync1_q;
   reg rst_sync2_q;
   wire rst_n;

   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync1_q <= 1'b0;
         rst_sync2_q <= 1'b0;
      end else begin
         rst_sync1_q <= 1'b1;
         rst_sync2_q <= rst_sync1_q;
      end
   end

   assign rst_n = rst_sync2_q;

   // ****************************************************************
   // Address decode
   // ****************************************************************

   wire sel_irq_en;
   wire sel_fwd_hi;
   wire sel_fwd_mid_hi;
   wire fwd_write_ok;

   assign sel_irq_en = (i_xfr_addr == `ADDR_INTERRUPT_ENABLE);
   assign sel_fwd_hi = (i_xfr_addr == `ADDR_FORWARD_ENABLE_HI);
   assign sel_fwd_mid_hi = (i_xfr_addr == `ADDR_FORWARD_ENABLE_MID_HI);

   // Operating mode turns the forward registers read-only; a refused write leaves no trace.
   assign fwd_write_ok = i_xfr_wr & i_silent_mode;

   // ****************************************************************
   // Registers
   // ****************************************************************

   reg [7:0] interrupt_enable_q;
   reg [7:0] forward_enable_hi_q;
   reg [7:0] forward_enable_mid_hi_q;

   // The reserved bit stays zero so software always reads back a clean value.
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_enable_q <= `RST_INTERRUPT_ENABLE;
      end else if (i_clk_en && i_xfr_wr && sel_irq_en) begin
         interrupt_enable_q <= i_xfr_wdata & `MASK_INTERRUPT_ENABLE;
      end
   end

   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         forward_enable_hi_q <= `RST_FORWARD_ENABLE_HI;
      end else if (i_clk_en && fwd_write_ok && sel_fwd_hi) begin
         forward_enable_hi_q <= i_xfr_wdata;
      end
   end

   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         forward_enable_mid_hi_q <= `RST_FORWARD_ENABLE_MID_HI;
      end else if (i_clk_en && fwd_write_ok && sel_fwd_mid_hi) begin
         forward_enable_mid_hi_q <= i_xfr_wdata;
      end
   end

   // Bit 15 is filter 31, bit 0 is filter 16.
   assign o_forward_en = {forward_enable_hi_q, forward_enable_mid_hi_q};

   // ****************************************************************
   // Read path
   // ****************************************************************

   reg [7:0] rdata_d;
   reg hit_d;

   always @* begin
      rdata_d = `RST_READ_DATA;
      hit_d = 1'b1;
      if (sel_irq_en) begin
         rdata_d = interrupt_enable_q;
      end else if (sel_fwd_hi) begin
         rdata_d = forward_enable_hi_q;
      end else if (sel_fwd_mid_hi) begin
         rdata_d = forward_enable_mid_hi_q;
      end else begin
         hit_d = 1'b0;
      end
   end

   // Unmapped addresses give no valid strobe so other register blocks may answer instead.
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_xfr_rdata <= `RST_READ_DATA;
         o_xfr_rvalid <= 1'b0;
      end else if (i_clk_en) begin
         o_xfr_rvalid <= i_xfr_rd & hit_d;
         if (i_xfr_rd && hit_d) begin
            o_xfr_rdata <= rdata_d;
         end
      end
   end

   // ****************************************************************
   // Interrupt flags
   // ****************************************************************

   wire en_err;
   wire en_tx;
   wire en_rx;
   reg tx_released_prev_q;
   wire tx_released_rise;
   wire set_err;
   wire set_tx;

   assign en_err = interrupt_enable_q[`BIT_ERROR_WARNING_IRQ_EN];
   assign en_tx = interrupt_enable_q[`BIT_TRANSMIT_IRQ_EN];
   assign en_rx = interrupt_enable_q[`BIT_RECEIVE_IRQ_EN];

   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_released_prev_q <= 1'b0;
      end else if (i_clk_en) begin
         tx_released_prev_q <= i_tx_buf_released;
      end
   end

   assign tx_released_rise = i_tx_buf_released & ~tx_released_prev_q;
   assign set_err = en_err & i_err_status_change;
   assign set_tx = en_tx & (i_tx_done | tx_released_rise);

   // A flag register read clears the sticky flags, but a new event in that cycle wins.
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_error_warning_irq_flag <= 1'b0;
         o_transmit_irq_flag <= 1'b0;
      end else if (i_clk_en) begin
         if (set_err) begin
            o_error_warning_irq_flag <= 1'b1;
         end else if (i_flag_reg_read) begin
            o_error_warning_irq_flag <= 1'b0;
         end
         if (set_tx) begin
            o_transmit_irq_flag <= 1'b1;
         end else if (i_flag_reg_read) begin
            o_transmit_irq_flag <= 1'b0;
         end
      end
   end

   // The receive flag mirrors the FIFO state, so a flag read has no effect on it.
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_receive_irq_flag <= 1'b0;
      end else if (i_clk_en) begin
         o_receive_irq_flag <= en_rx & i_rx_fifo_not_empty;
      end
   end

   assign o_irq = o_error_warning_irq_flag | o_transmit_irq_flag | o_receive_irq_flag;

   // ****************************************************************
   // Forward decision
   // ****************************************************************

   // A message is forwarded only if some matching filter has its forward bit set.
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_forward_msg <= 1'b0;
      end else if (i_clk_en) begin
         o_forward_msg <= |(i_filter_hit & o_forward_en);
      end
   end

endmodule // can_irq_enable_forward_regs_top

// [test/can_regs_monitor.sv]
// Concurrent checks on the ports of the CAN enable register block.
// Assumes every port shares i_clk and i_arst_n.
`timescale 1ns/1ns
`include "can_irq_enable_forward_regs.vh"
module can_regs_monitor (
   input wire i_clk, i_arst_n, i_clk_en, i_xfr_wr, i_xfr_rd, i_silent_mode,
   input wire i_err_status_change, i_tx_done, i_tx_buf_released, i_rx_fifo_not_empty, i_flag_reg_read,
   input wire [15:0] i_xfr_addr, i_filter_hit, o_forward_en,
   input wire [7:0] i_xfr_wdata,
   input wire o_xfr_rvalid, o_error_warning_irq_flag, o_transmit_irq_flag,
   input wire o_receive_irq_flag, o_irq, o_forward_msg
);
   // The enable bits are internal, so they are rebuilt here from the writes.
   reg [2:0] en_q;
   wire fw_wr = i_clk_en && i_xfr_wr && i_silent_mode;
   wire map = i_xfr_addr >= `ADDR_INTERRUPT_ENABLE && i_xfr_addr <= `ADDR_FORWARD_ENABLE_MID_HI;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         en_q <= 3'h0;
      else if (i_clk_en && i_xfr_wr && i_xfr_addr == `ADDR_INTERRUPT_ENABLE)
         en_q <= i_xfr_wdata[2:0];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_err_flag_set: assert property (i_clk_en && i_err_status_change && en_q[2] |=> o_error_warning_irq_flag)
      else $error("warning flag missed");
   a_err_flag_off: assert property (i_clk_en && !en_q[2] && !o_error_warning_irq_flag |=> !o_error_warning_irq_flag)
      else $error("warning flag while disabled");
   a_tx_flag_set: assert property (i_clk_en && i_tx_done && en_q[1] |=> o_transmit_irq_flag)
      else $error("transmit flag missed");
   a_tx_rise_set: assert property (i_clk_en && $past(i_clk_en) && $rose(i_tx_buf_released) && en_q[1] |=> o_transmit_irq_flag)
      else $error("transmit release flag missed");
   a_rx_flag_follow: assert property (i_clk_en |=> o_receive_irq_flag == $past(en_q[0] && i_rx_fifo_not_empty))
      else $error("receive flag wrong");
   a_irq_or_flags: assert property (o_irq == (o_error_warning_irq_flag || o_transmit_irq_flag || o_receive_irq_flag))
      else $error("request wrong");
   a_fwd_write_hi: assert property (fw_wr && i_xfr_addr == `ADDR_FORWARD_ENABLE_HI |=> o_forward_en[15:8] == $past(i_xfr_wdata))
      else $error("upper forward write lost");
   a_fwd_write_mid: assert property (fw_wr && i_xfr_addr == `ADDR_FORWARD_ENABLE_MID_HI |=> o_forward_en[7:0] == $past(i_xfr_wdata))
      else $error("second forward write lost");
   a_fwd_locked: assert property (i_clk_en && !i_silent_mode |=> $stable(o_forward_en))
      else $error("forward changed in operating mode");
   a_fwd_decision: assert property (i_clk_en |=> o_forward_msg == $past(|(i_filter_hit & o_forward_en)))
      else $error("forward decision wrong");
   a_read_answer: assert property (i_clk_en && i_xfr_rd |=> o_xfr_rvalid == $past(map))
      else $error("read answer wrong");
   c_err_event: cover property (en_q[2] && i_err_status_change);
   c_fwd_write: cover property (fw_wr);
   c_flag_read: cover property (i_flag_reg_read && o_receive_irq_flag);
endmodule // can_regs_monitor
bind can_irq_enable_forward_regs_top can_regs_monitor u_mon (.*);

// [test/can_engine_model.sv]
// Behavioural protocol engine feeding status events and filter hits.
// Assumes it shares i_clk with the block; it acts 2 ns after an edge.
`timescale 1ns/1ns
module can_engine_model (
   input wire i_clk,
   output reg o_err = 1'b0,
   output reg o_txd = 1'b0,
   output reg o_rel = 1'b0,
   output reg o_rxne = 1'b0,
   output reg [15:0] o_hit = 16'h0000
);
   // Events are single-cycle pulses; kind 0 is a status change, else a sent frame.
   // One idle cycle follows each pulse so that two calls never touch a line in one time step.
   task pulse(input integer k);
      begin
         if (k == 0)
            o_err = 1'b1;
         else
            o_txd = 1'b1;
         @(posedge i_clk);
         #2;
         if (k == 0)
            o_err = 1'b0;
         else
            o_txd = 1'b0;
         @(posedge i_clk);
         #2;
      end
   endtask
endmodule // can_engine_model

// [test/test_can_irq_enable_forward_regs.sv]
// Self-checking bench for the CAN enable register block.
// Assumes a 50 MHz clock and the engine model beside the block.
`timescale 1ns/1ns
`include "can_irq_enable_forward_regs.vh"
module test_can_irq_enable_forward_regs;
   reg i_clk = 1'b0;
   reg i_arst_n = 1'b0;
   reg cke = 1'b1;
   reg wr_s = 1'b0, rd_s = 1'b0, silent = 1'b0, flag_rd = 1'b0;
   reg [15:0] addr = 16'h0000;
   reg [7:0] wdata = 8'h00;
   wire [7:0] rdata;
   wire [15:0] fwd_en, hit;
   wire err_f, tx_f, rx_f, irq, fwd_msg, rvalid, ev_err, ev_txd, rel, rxne;
   integer err_total = 0, compares = 0, i;
   initial forever #10 i_clk = ~i_clk;
   can_engine_model u_eng (.i_clk(i_clk), .o_err(ev_err), .o_txd(ev_txd), .o_rel(rel), .o_rxne(rxne), .o_hit(hit));
   can_irq_enable_forward_regs_top u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_clk_en(cke),
      .i_xfr_addr(addr), .i_xfr_wr(wr_s), .i_xfr_rd(rd_s), .i_xfr_wdata(wdata), .o_xfr_rdata(rdata),
      .o_xfr_rvalid(rvalid), .i_silent_mode(silent), .i_err_status_change(ev_err), .i_tx_done(ev_txd),
      .i_tx_buf_released(rel), .i_rx_fifo_not_empty(rxne), .i_flag_reg_read(flag_rd), .i_filter_hit(hit),
      .o_error_warning_irq_flag(err_f), .o_transmit_irq_flag(tx_f), .o_receive_irq_flag(rx_f),
      .o_irq(irq), .o_forward_en(fwd_en), .o_forward_msg(fwd_msg));
   task step;
      begin
         @(posedge i_clk);
         #2;
      end
   endtask
   task chk(input [15:0] s, input [15:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: saw %h want %h", $time, s, e);
         end
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         addr = a;
         wdata = d;
         wr_s = 1'b1;
         step;
         wr_s = 1'b0;
         step;
      end
   endtask
   task rd(input [15:0] a, input v, input [7:0] d);
      begin
         addr = a;
         rd_s = 1'b1;
         step;
         rd_s = 1'b0;
         chk(rvalid, v);
         if (v)
            chk(rdata, d);
         step;
      end
   endtask
   task clr;
      begin
         flag_rd = 1'b1;
         step;
         flag_rd = 1'b0;
         step;
      end
   endtask
   task t_reset;
      begin
         i_arst_n = 1'b0;
         repeat (3) step;
         i_arst_n = 1'b1;
         repeat (3) step;
         chk(fwd_en, 16'h0000);
         chk({err_f, tx_f, rx_f, irq}, 4'h0);
         rd(`ADDR_INTERRUPT_ENABLE, 1'b1, 8'h00);
         rd(`ADDR_FORWARD_ENABLE_HI, 1'b1, 8'h00);
         rd(`ADDR_FORWARD_ENABLE_MID_HI, 1'b1, 8'h00);
      end
   endtask
   task t_regs;
      begin
         wr(`ADDR_INTERRUPT_ENABLE, 8'hFF);
         rd(`ADDR_INTERRUPT_ENABLE, 1'b1, 8'hEF);
         silent = 1'b1;
         wr(`ADDR_FORWARD_ENABLE_HI, 8'hA5);
         wr(`ADDR_FORWARD_ENABLE_MID_HI, 8'h3C);
         chk(fwd_en, 16'hA53C);
         silent = 1'b0;
         wr(`ADDR_FORWARD_ENABLE_HI, 8'h00);
         wr(`ADDR_FORWARD_ENABLE_MID_HI, 8'hFF);
         rd(`ADDR_FORWARD_ENABLE_HI, 1'b1, 8'hA5);
         rd(`ADDR_FORWARD_ENABLE_MID_HI, 1'b1, 8'h3C);
         rd(16'h0B07, 1'b0, 8'h00);
         cke = 1'b0;
         wr(`ADDR_INTERRUPT_ENABLE, 8'h00);
         rd(`ADDR_INTERRUPT_ENABLE, 1'b0, 8'h00);
         cke = 1'b1;
         rd(`ADDR_INTERRUPT_ENABLE, 1'b1, 8'hEF);
      end
   endtask
   task t_fwd;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            u_eng.o_hit = 16'h0001 << i;
            step;
            chk(fwd_msg, 16'hA53C >> i & 16'h0001);
         end
         u_eng.o_hit = 16'h0000;
      end
   endtask
   task t_irq;
      begin
         wr(`ADDR_INTERRUPT_ENABLE, 8'h00);
         u_eng.o_rxne = 1'b1;
         u_eng.pulse(0);
         u_eng.pulse(1);
         chk({err_f, tx_f, rx_f, irq}, 4'h0);
         wr(`ADDR_INTERRUPT_ENABLE, 8'h07);
         u_eng.pulse(0);
         chk({err_f, tx_f, rx_f, irq}, 4'hB);
         clr;
         chk({err_f, rx_f}, 2'h1);
         u_eng.pulse(1);
         chk(tx_f, 1'b1);
         clr;
         chk(tx_f, 1'b0);
         u_eng.o_rel = 1'b1;
         step;
         chk(tx_f, 1'b1);
         clr;
         u_eng.o_rxne = 1'b0;
         step;
         chk({tx_f, rx_f, irq}, 3'h0);
         u_eng.pulse(0);
         chk({err_f, irq}, 2'h3);
      end
   endtask
   task complete_run;
      begin
         $display("compares %0d mismatches %0d", compares, err_total);
         if (err_total == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      t_reset;
      t_regs;
      t_fwd;
      t_irq;
      t_reset;
      complete_run;
   end
   // Whole run needs about 90 cycles; this leaves wide margin.
   initial begin
      #100000;
      err_total = err_total + 1;
      complete_run;
   end
endmodule // test_can_irq_enable_forward_regs
